/* hw/tcw_channel.sv */
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module tcw_channel
  import tcw_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [DATA_W-1:0]  i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [DATA_W-1:0]  o_rdata,
  input  wire logic               i_line_a,
  output logic                    o_line_a,
  output logic                    o_line_a_oe,
  input  wire logic               i_line_b,
  output logic                    o_line_b,
  output logic                    o_line_b_oe,
  input  wire logic               i_ext_clock_0,
  input  wire logic               i_ext_clock_1,
  input  wire logic               i_ext_clock_2
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  function automatic logic [1:0] fld2(input logic [31:0] r, input int pos);
    return r[pos +: 2];
  endfunction

  function automatic logic act_apply(input logic [1:0] act, input logic cur, input logic ev);
    logic v;
    v = cur;
    if (ev) begin
      unique case (act)
        ACT_NONE: v = cur;
        ACT_SET:  v = 1'b1;
        ACT_CLR:  v = 1'b0;
        ACT_TOG:  v = ~cur;
      endcase
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [4:0]        pins_raw;
  logic [4:0]        sync1_q;
  logic [4:0]        sync2_q;
  logic              ev_prev_q;
  logic              la_prev_q;
  logic [31:0]       mode_q;
  logic [15:0]       cnt_q;
  logic [15:0]       ra_q;
  logic [15:0]       rb_q;
  logic [15:0]       rc_q;
  tcw_dir_t          dir_q;
  logic              clk_on_q;
  logic [7:0]        flags_q;
  logic              a_unread_q;
  logic              b_unread_q;
  logic              line_a_q;
  logic              line_a_oe_q;
  logic              line_b_q;
  logic              line_b_oe_q;
  logic [DATA_W-1:0] rdata_q;

  logic              wave;
  logic              b_drive;
  logic              ev_src;
  logic              ev_rise;
  logic              ev_fall;
  logic              ev_det;
  logic              ext_trig;
  logic              sw_trig;
  logic              clk_en_cmd;
  logic              clk_dis_cmd;
  logic              match_a;
  logic              match_b;
  logic              match_c;
  logic              c_trig;
  logic              any_trig;
  logic              ovf_ev;
  logic              load_a;
  logic              load_b;
  logic              overrun;
  logic              sr_read;
  logic [7:0]        flag_set;
  logic [7:0]        flag_view;
  logic              mirror_a;
  logic              mirror_b;
  logic              line_a_d;
  logic              line_b_d;
  logic [DATA_W-1:0] rdata_d;

  assign o_rdata     = rdata_q;
  assign o_line_a    = line_a_q;
  assign o_line_a_oe = line_a_oe_q;
  assign o_line_b    = line_b_q;
  assign o_line_b_oe = line_b_oe_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pins_raw = {i_ext_clock_2, i_ext_clock_1, i_ext_clock_0, i_line_b, i_line_a};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // mode and command decode
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_q <= MODE_RST;
    end else if (i_wr && hit(i_addr, OFF_MODE)) begin
      mode_q <= i_wdata;
    end
  end

  assign wave        = mode_q[MD_WAVE];
  assign b_drive     = wave && (fld2(mode_q, MD_EVSEL) != EV_LINE_B);
  assign sw_trig     = i_wr && hit(i_addr, OFF_CMD) && i_wdata[CMD_SW_TRIG];
  assign clk_en_cmd  = i_wr && hit(i_addr, OFF_CMD) && i_wdata[CMD_CLK_EN];
  assign clk_dis_cmd = i_wr && hit(i_addr, OFF_CMD) && i_wdata[CMD_CLK_DIS];
  assign sr_read     = i_rd && hit(i_addr, OFF_SR);

  // ----------------------------------------------------------------
  // external event
  // ----------------------------------------------------------------
  always_comb begin
    unique case (fld2(mode_q, MD_EVSEL))
      EV_LINE_B: ev_src = sync2_q[1];
      EV_EXT_0:  ev_src = sync2_q[2];
      EV_EXT_1:  ev_src = sync2_q[3];
      EV_EXT_2:  ev_src = sync2_q[4];
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ev_prev_q <= 1'b0;
      la_prev_q <= 1'b0;
    end else begin
      ev_prev_q <= ev_src;
      la_prev_q <= sync2_q[0];
    end
  end

  assign ev_rise = ev_src && !ev_prev_q;
  assign ev_fall = !ev_src && ev_prev_q;

  always_comb begin
    unique case (fld2(mode_q, MD_EDGE))
      EDGE_NONE: ev_det = 1'b0;
      EDGE_RISE: ev_det = ev_rise;
      EDGE_FALL: ev_det = ev_fall;
      EDGE_BOTH: ev_det = ev_rise || ev_fall;
    endcase
  end

  assign ext_trig = ev_det && mode_q[MD_TRIG_EN];

  // ----------------------------------------------------------------
  // compare and counter
  // ----------------------------------------------------------------
  // matches only count while the clock runs, so a stopped counter
  // parked on a compare value does not flood the flags
  assign match_a  = wave && clk_on_q && (cnt_q == ra_q);
  assign match_b  = wave && clk_on_q && (cnt_q == rb_q);
  assign match_c  = clk_on_q && (cnt_q == rc_q);
  assign c_trig   = match_c && mode_q[MD_SHAPE + SHAPE_CTRIG]
                    && !mode_q[MD_SHAPE + SHAPE_UPDOWN];
  assign any_trig = ext_trig || sw_trig || c_trig;
  assign ovf_ev   = clk_on_q && !any_trig && (dir_q == DIR_UP) && (cnt_q == CNT_MAX);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      clk_on_q <= 1'b0;
    end else if (clk_dis_cmd) begin
      clk_on_q <= 1'b0;
    end else if (any_trig || clk_en_cmd) begin
      clk_on_q <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_q <= CNT_RST;
      dir_q <= DIR_UP;
    end else if (any_trig) begin
      cnt_q <= CNT_RST;
      dir_q <= DIR_UP;
    end else if (clk_on_q) begin
      if (!mode_q[MD_SHAPE + SHAPE_UPDOWN]) begin
        cnt_q <= cnt_q + 16'h0001;
      end else if (dir_q == DIR_UP) begin
        // up-down turns at the top, or at compare c when triggering
        if (cnt_q == CNT_MAX || (mode_q[MD_SHAPE + SHAPE_CTRIG] && cnt_q == rc_q)) begin
          cnt_q <= cnt_q - 16'h0001;
          dir_q <= DIR_DOWN;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else begin
        if (cnt_q == CNT_RST) begin
          cnt_q <= cnt_q + 16'h0001;
          dir_q <= DIR_UP;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // capture loads and value registers
  // ----------------------------------------------------------------
  assign load_a  = !wave && sync2_q[0] && !la_prev_q;
  assign load_b  = !wave && !sync2_q[0] && la_prev_q;
  assign overrun = (load_a && a_unread_q) || (load_b && b_unread_q);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ra_q <= CMP_RST;
    end else if (load_a) begin
      ra_q <= cnt_q;
    end else if (wave && i_wr && hit(i_addr, OFF_RA)) begin
      ra_q <= i_wdata[15:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rb_q <= CMP_RST;
    end else if (load_b) begin
      rb_q <= cnt_q;
    end else if (wave && i_wr && hit(i_addr, OFF_RB)) begin
      rb_q <= i_wdata[15:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rc_q <= CMP_RST;
    end else if (i_wr && hit(i_addr, OFF_RC)) begin
      rc_q <= i_wdata[15:0];
    end
  end

  // a load in the same cycle as the register read still counts as unread
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      a_unread_q <= 1'b0;
      b_unread_q <= 1'b0;
    end else begin
      a_unread_q <= load_a || (a_unread_q && !(i_rd && hit(i_addr, OFF_RA)));
      b_unread_q <= load_b || (b_unread_q && !(i_rd && hit(i_addr, OFF_RB)));
    end
  end

  // ----------------------------------------------------------------
  // waveform outputs
  // ----------------------------------------------------------------
  // later actions win: software trigger over event over c over a/b
  always_comb begin
    line_a_d = line_a_q;
    line_a_d = act_apply(fld2(mode_q, MD_A_MA), line_a_d, match_a);
    line_a_d = act_apply(fld2(mode_q, MD_A_MC), line_a_d, match_c);
    line_a_d = act_apply(fld2(mode_q, MD_A_EXT), line_a_d, ev_det);
    line_a_d = act_apply(fld2(mode_q, MD_A_SW), line_a_d, sw_trig);
    line_b_d = line_b_q;
    line_b_d = act_apply(fld2(mode_q, MD_B_MB), line_b_d, match_b);
    line_b_d = act_apply(fld2(mode_q, MD_B_MC), line_b_d, match_c);
    line_b_d = act_apply(fld2(mode_q, MD_B_EXT), line_b_d, ev_det);
    line_b_d = act_apply(fld2(mode_q, MD_B_SW), line_b_d, sw_trig);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      line_a_q    <= 1'b0;
      line_a_oe_q <= 1'b0;
    end else begin
      line_a_oe_q <= wave;
      if (wave) begin
        line_a_q <= line_a_d;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      line_b_q    <= 1'b0;
      line_b_oe_q <= 1'b0;
    end else begin
      line_b_oe_q <= b_drive;
      if (b_drive) begin
        line_b_q <= line_b_d;
      end
    end
  end

  assign mirror_a = line_a_oe_q ? line_a_q : sync2_q[0];
  assign mirror_b = line_b_oe_q ? line_b_q : sync2_q[1];

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb begin
    flag_set          = 8'h00;
    flag_set[SR_OVF]  = ovf_ev;
    flag_set[SR_OVR]  = overrun;
    flag_set[SR_MA]   = match_a;
    flag_set[SR_MB]   = match_b && b_drive;
    flag_set[SR_MC]   = match_c;
    flag_set[SR_LDA]  = load_a;
    flag_set[SR_LDB]  = load_b;
    flag_set[SR_ETRG] = ext_trig;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flag_set | (flags_q & ~{8{sr_read}});
    end
  end

  // mode-dependent bits read zero in the other mode
  always_comb begin
    flag_view         = flags_q;
    flag_view[SR_OVR] = flags_q[SR_OVR] && !wave;
    flag_view[SR_MA]  = flags_q[SR_MA] && wave;
    flag_view[SR_MB]  = flags_q[SR_MB] && wave;
    flag_view[SR_LDA] = flags_q[SR_LDA] && !wave;
    flag_view[SR_LDB] = flags_q[SR_LDB] && !wave;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      if (hit(i_addr, OFF_MODE)) begin
        rdata_d = mode_q;
      end else if (hit(i_addr, OFF_CV)) begin
        rdata_d[15:0] = cnt_q;
      end else if (hit(i_addr, OFF_RA)) begin
        rdata_d[15:0] = ra_q;
      end else if (hit(i_addr, OFF_RB)) begin
        rdata_d[15:0] = rb_q;
      end else if (hit(i_addr, OFF_RC)) begin
        rdata_d[15:0] = rc_q;
      end else if (hit(i_addr, OFF_SR)) begin
        rdata_d[7:0]    = flag_view;
        rdata_d[SR_CLK]  = clk_on_q;
        rdata_d[SR_MIRA] = mirror_a;
        rdata_d[SR_MIRB] = mirror_b;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_rc_write;
    i_wr && hit(i_addr, OFF_RC);
  endsequence

  // one idle cycle between write and read, as a plain bus master leaves it
  sequence s_rc_read_next;
    !i_wr ##1 (i_rd && hit(i_addr, OFF_RC) && !i_wr);
  endsequence

  a_trig_zeroes: assert property (ext_trig && !clk_dis_cmd |=> cnt_q == CNT_RST && clk_on_q)
    else $error("external trigger did not zero and start counter");

  a_event_no_count: assert property (ev_det && !mode_q[MD_TRIG_EN] && !sw_trig && !clk_on_q
                                     && !clk_en_cmd |=> !clk_on_q && $stable(cnt_q))
    else $error("untriggered event disturbed the counter");

  a_line_b_input: assert property (fld2(mode_q, MD_EVSEL) == EV_LINE_B |=> !o_line_b_oe)
    else $error("line b driven while used as event source");

  a_edge_rise: assert property (fld2(mode_q, MD_EDGE) == EDGE_RISE && ev_fall |-> !ev_det)
    else $error("falling edge detected in rising mode");

  a_c_trigger: assert property (c_trig && !clk_dis_cmd |=> cnt_q == CNT_RST
                                ##1 ($past(any_trig) || cnt_q == 16'h0001))
    else $error("compare c trigger did not restart counter");

  a_ovf_flag: assert property (ovf_ev |=> flags_q[SR_OVF])
    else $error("overflow not flagged");

  a_read_clears: assert property (sr_read && flag_set == 8'h00 |=> flags_q == 8'h00)
    else $error("status read did not clear flags");

  a_set_wins: assert property (sr_read && match_c |=> flags_q[SR_MC])
    else $error("event lost under status read");

  a_wave_masks: assert property (!wave && sr_read |=> o_rdata[3:2] == 2'h0)
    else $error("match a/b flags visible in capture mode");

  a_ra_readonly: assert property (!wave && i_wr && hit(i_addr, OFF_RA) && !load_a
                                  |=> ra_q == $past(ra_q))
    else $error("value a written in capture mode");

  a_rc_roundtrip: assert property (s_rc_write ##1 s_rc_read_next |=> o_rdata == {16'h0000,
                                   $past(i_wdata[15:0], 3)})
    else $error("compare c read back wrong");

  a_cv_read: assert property (i_rd && hit(i_addr, OFF_CV) |=> o_rdata == {16'h0000,
                              $past(cnt_q)})
    else $error("counter value read wrong");

  a_clk_status: assert property (sr_read |=> o_rdata[SR_CLK] == $past(clk_on_q))
    else $error("clock status bit wrong");

  a_sw_toggle: assert property (wave && sw_trig && fld2(mode_q, MD_A_SW) == ACT_TOG
                                |=> o_line_a != $past(o_line_a))
    else $error("software trigger did not toggle line a");

endmodule // tcw_channel

/* hw/tcw_pkg.sv */
package tcw_pkg;

  // ----------------------------------------------------------------
  // bus and widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  localparam logic [7:0] OFF_CMD  = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CV   = 8'h10;
  localparam logic [7:0] OFF_RA   = 8'h14;
  localparam logic [7:0] OFF_RB   = 8'h18;
  localparam logic [7:0] OFF_RC   = 8'h1c;
  localparam logic [7:0] OFF_SR   = 8'h20;

  // ----------------------------------------------------------------
  // command bits (write-only, self clearing)
  // ----------------------------------------------------------------
  localparam int CMD_CLK_EN  = 0;
  localparam int CMD_CLK_DIS = 1;
  localparam int CMD_SW_TRIG = 2;

  // ----------------------------------------------------------------
  // mode register field positions
  // ----------------------------------------------------------------
  localparam int MD_EDGE    = 8;
  localparam int MD_EVSEL   = 10;
  localparam int MD_TRIG_EN = 12;
  localparam int MD_SHAPE   = 13;
  localparam int MD_WAVE    = 15;
  localparam int MD_A_MA    = 16;
  localparam int MD_A_MC    = 18;
  localparam int MD_A_EXT   = 20;
  localparam int MD_A_SW    = 22;
  localparam int MD_B_MB    = 24;
  localparam int MD_B_MC    = 26;
  localparam int MD_B_EXT   = 28;
  localparam int MD_B_SW    = 30;

  localparam int SHAPE_UPDOWN = 0;
  localparam int SHAPE_CTRIG  = 1;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int SR_OVF   = 0;
  localparam int SR_OVR   = 1;
  localparam int SR_MA    = 2;
  localparam int SR_MB    = 3;
  localparam int SR_MC    = 4;
  localparam int SR_LDA   = 5;
  localparam int SR_LDB   = 6;
  localparam int SR_ETRG  = 7;
  localparam int SR_CLK   = 16;
  localparam int SR_MIRA  = 17;
  localparam int SR_MIRB  = 18;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET  = 2'h1;
  localparam logic [1:0] ACT_CLR  = 2'h2;
  localparam logic [1:0] ACT_TOG  = 2'h3;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] EV_LINE_B = 2'h0;
  localparam logic [1:0] EV_EXT_0  = 2'h1;
  localparam logic [1:0] EV_EXT_1  = 2'h2;
  localparam logic [1:0] EV_EXT_2  = 2'h3;

  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  typedef enum logic {DIR_UP, DIR_DOWN} tcw_dir_t;

endpackage

/* sim/tcw_far_side.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side of the channel pins
// ----------------------------------------------------------------
module tcw_far_side (
  input  wire logic       i_far_a,
  input  wire logic       i_far_b,
  input  wire logic [2:0] i_ext_level,
  input  wire logic       i_drv_a,
  input  wire logic       i_drv_a_oe,
  input  wire logic       i_drv_b,
  input  wire logic       i_drv_b_oe,
  output logic            o_pin_a,
  output logic            o_pin_b,
  output logic [2:0]      o_ext
);
  // far side lets go while the channel drives; contention not modelled
  assign o_pin_a = i_drv_a_oe ? i_drv_a : i_far_a;
  assign o_pin_b = i_drv_b_oe ? i_drv_b : i_far_b;
  // event sources are plain levels, stepped only by the bench
  assign o_ext   = i_ext_level;
endmodule // tcw_far_side

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import tcw_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              i_ref_clk = 1'b0;
  logic              i_rst     = 1'b1;
  logic [ADDR_W-1:0] i_addr    = 8'h00;
  logic [DATA_W-1:0] i_wdata   = 32'h0;
  logic              i_wr      = 1'b0;
  logic              i_rd      = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic              o_line_a, o_line_a_oe, o_line_b, o_line_b_oe, i_line_a, i_line_b;
  logic [2:0]        ext;
  logic              far_a     = 1'b0;
  logic [3:0]        src       = 4'h0;
  logic              pend      = 1'b0;
  logic              la        = 1'b0;
  logic              lb        = 1'b0;
  logic [1:0]        es;
  logic [15:0]       rv;
  logic [31:0]       ev, mv, mode;
  logic [31:0]       wv        = 32'h1 << MD_WAVE;
  logic [31:0]       exp_q[$], msk_q[$];
  int                n_errors  = 0;
  int                num_checks = 0;
  int                seed      = 6948;

  always #2 i_ref_clk = ~i_ref_clk;

  tcw_channel i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line_a(i_line_a), .o_line_a(o_line_a),
    .o_line_a_oe(o_line_a_oe), .i_line_b(i_line_b), .o_line_b(o_line_b),
    .o_line_b_oe(o_line_b_oe), .i_ext_clock_0(ext[0]), .i_ext_clock_1(ext[1]),
    .i_ext_clock_2(ext[2]));

  tcw_far_side i_far (.i_far_a(far_a), .i_far_b(src[0]), .i_ext_level(src[3:1]),
    .i_drv_a(o_line_a), .i_drv_a_oe(o_line_a_oe), .i_drv_b(o_line_b),
    .i_drv_b_oe(o_line_b_oe), .o_pin_a(i_line_a), .o_pin_b(i_line_b), .o_ext(ext));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] expv);
    num_checks++;
    if (got !== expv) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, expv);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
  endtask

  // expectation noted now, compared by the watcher when data appear
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
  endtask

  // pin actions land a few cycles late; bounded wait for the level
  task automatic pin(input logic ea, input logic eb);
    int k;
    k = 0;
    while ((o_line_a !== ea || o_line_b !== eb) && k < 10) begin
      @(posedge i_ref_clk);
      k++;
    end
    check({30'h0, o_line_b, o_line_a}, {30'h0, eb, ea});
    if (k == 10 && {o_line_b, o_line_a} !== {eb, ea}) complete_run();
  endtask

  function automatic logic act(input logic [1:0] c, input logic v);
    return (c == ACT_SET) ? 1'b1 : (c == ACT_CLR) ? 1'b0 : (c == ACT_TOG) ? ~v : v;
  endfunction

  always @(posedge i_ref_clk) begin
    if (pend) begin
      ev = exp_q.pop_front();
      mv = msk_q.pop_front();
      check(o_rdata & mv, ev);
    end
    pend <= i_rd;
  end

  initial begin
    #400000;
    n_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    i_rst <= 1'b0;
    rd(OFF_SR, 32'h0, 32'hffff_ffff);
    rd(OFF_CV, 32'h0, 32'hffff_ffff);
    rd(8'h3c, 32'h0, 32'hffff_ffff);
    rv = 16'($random(seed));
    wr(OFF_RA, {16'h0, rv});
    wr(OFF_RC, {16'h0, rv});
    rd(OFF_RC, {16'h0, rv}, 32'hffff_ffff);
    rd(OFF_RA, 32'h0, 32'hffff_ffff);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      wr(OFF_MODE, wv | (32'(c) << MD_A_SW) | (32'(c) << MD_B_SW) | (32'h1 << MD_EVSEL));
      repeat (2) begin
        wr(OFF_CMD, 32'h1 << CMD_SW_TRIG);
        la = act(2'(c), la);
        lb = act(2'(c), lb);
        pin(la, lb);
      end
    end
    check({31'h0, o_line_b_oe}, 32'h1);
    rd(OFF_SR, {13'h0, lb, la, 1'b1, 16'h0}, 32'h0007_0000);
    wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
    rd(OFF_SR, 32'h0, 32'h0001_0000);
    wr(OFF_MODE, wv);
    cyc(2);
    check({31'h0, o_line_b_oe}, 32'h0);
    $display("test software trigger done");
    // source 0 is line b as an input, 1..3 the external clocks
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 4; e++) begin
        es = 2'(e);
        mode = wv | (32'(e) << MD_EDGE) | (32'(s) << MD_EVSEL) | (32'h1 << MD_TRIG_EN);
        wr(OFF_MODE, mode | (32'(ACT_TOG) << MD_A_EXT));
        rd(OFF_SR, 32'h0, 32'h0);
        src[s] <= 1'b1;
        cyc(6);
        if (es[0]) la = ~la;
        rd(OFF_SR, {14'h0, la, es[0], 8'h0, es[0], 7'h0}, 32'h0003_0080);
        wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
        src[s] <= 1'b0;
        cyc(6);
        if (es[1]) la = ~la;
        rd(OFF_SR, {14'h0, la, es[1], 8'h0, es[1], 7'h0}, 32'h0003_0080);
        wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
      end
    end
    wr(OFF_MODE, wv | (32'h1 << MD_EDGE) | (32'h1 << MD_EVSEL) | (32'(ACT_TOG) << MD_A_EXT));
    src[1] <= 1'b1;
    cyc(6);
    la = ~la;
    rd(OFF_SR, {14'h0, la, 17'h0}, 32'h0003_0000);
    src[1] <= 1'b0;
    $display("test external event done");
    // line b driven here, otherwise match b raises no flag
    wr(OFF_MODE, wv | (32'h2 << MD_SHAPE) | (32'h1 << MD_EVSEL));
    wr(OFF_RA, 32'h10);
    wr(OFF_RB, 32'h18);
    wr(OFF_RC, 32'h20);
    rd(OFF_RA, 32'h10, 32'hffff_ffff);
    rd(OFF_RB, 32'h18, 32'hffff_ffff);
    rd(OFF_SR, 32'h0, 32'h0);
    wr(OFF_CMD, 32'h1 << CMD_SW_TRIG);
    cyc(100);
    wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
    rd(OFF_CV, 32'h3, 32'hffff_ffff);
    rd(OFF_SR, 32'h1c, 32'h7e);
    wr(OFF_MODE, wv);
    wr(OFF_CMD, 32'h1 << CMD_SW_TRIG);
    cyc(100);
    wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
    rd(OFF_CV, 32'h60, 32'hffff_ffe0);
    wr(OFF_MODE, wv | (32'h3 << MD_SHAPE));
    wr(OFF_CMD, 32'h1 << CMD_SW_TRIG);
    cyc(100);
    wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
    rd(OFF_CV, 32'h1a, 32'hffff_ffff);
    wr(OFF_MODE, wv);
    wr(OFF_CMD, 32'h1 << CMD_SW_TRIG);
    cyc(65600);
    rd(OFF_SR, 32'h1, 32'h1);
    rd(OFF_SR, 32'h0, 32'h1);
    wr(OFF_CMD, 32'h1 << CMD_CLK_DIS);
    $display("test counter shapes done");
    wr(OFF_MODE, 32'h0);
    cyc(2);
    check({30'h0, o_line_b_oe, o_line_a_oe}, 32'h0);
    wr(OFF_CMD, 32'h1 << CMD_CLK_EN);
    rd(OFF_SR, 32'h0, 32'h0);
    // line a fell as it was released: clear the unread mark of that load
    rd(OFF_RB, 32'h0, 32'h0);
    far_a <= 1'b1;
    cyc(6);
    rd(OFF_SR, 32'h0002_0020, 32'h0002_006e);
    far_a <= 1'b0;
    cyc(6);
    rd(OFF_SR, 32'h40, 32'h0002_006e);
    repeat (2) begin
      far_a <= 1'b1;
      cyc(6);
      far_a <= 1'b0;
      cyc(6);
    end
    rd(OFF_SR, 32'h62, 32'h6e);
    cyc(4);
    $display("test capture done");
    complete_run();
  end
endmodule // testbench
